// [tpc_drive_model.sv]
// Far-side model: fault source and external sync source of the inverter
`timescale 1ns/1ps
module tpc_drive_model
(
  input  wire logic pclk,
  input  wire logic trip_cmd,
  input  wire logic sync_cmd,
  output logic      fault_trip_pin,
  output logic      ext_sync_in
);
  initial begin
    fault_trip_pin = 1'b1;
    ext_sync_in    = 1'b0;
  end
  always @(posedge pclk) begin
    fault_trip_pin <= !trip_cmd;
    ext_sync_in    <= sync_cmd;
  end
endmodule

// [tpc_phase_out.sv]
// Output stage of one phase: compare, dead band, crossover, chopping, disable, trip gate
`timescale 1ns/1ps
module tpc_phase_out
  import tpc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  run,
  input  wire logic [TPC_CNT_W-1:0]  count,
  input  wire logic [TPC_CNT_W-1:0]  duty,
  input  wire logic [TPC_DEAD_W-1:0] dead,
  input  wire tpc_chan_ctrl_s        ctrl,
  input  wire logic                  chop_clk,
  input  wire logic                  trip_pin,
  output wire logic                  gate_high,
  output wire logic                  gate_low
);

  // ************************************************************
  // Compare with dead band on both edges
  // ************************************************************
  wire logic [TPC_CNT_W:0] cnt_ext    = {1'b0, count};
  wire logic [TPC_CNT_W:0] dead_ext   = {{(TPC_CNT_W+1-TPC_DEAD_W){1'b0}}, dead};
  wire logic [TPC_CNT_W:0] duty_ext   = {1'b0, duty};
  wire logic               raw_high   = (cnt_ext + dead_ext) < duty_ext;
  wire logic               raw_low    = cnt_ext >= (duty_ext + dead_ext);
  wire logic               sw_high    = ctrl.crossover ? raw_low  : raw_high;
  wire logic               sw_low     = ctrl.crossover ? raw_high : raw_low;
  wire logic               chop_high  = sw_high & (~ctrl.chop_high | chop_clk);
  wire logic               chop_low   = sw_low  & (~ctrl.chop_low  | chop_clk);
  wire logic               next_high  = run & chop_high & ~ctrl.dis_high;
  wire logic               next_low   = run & chop_low  & ~ctrl.dis_low;

  logic high_q;
  logic low_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_q <= 1'b0;
      low_q  <= 1'b0;
    end else begin
      high_q <= next_high;
      low_q  <= next_low;
    end
  end

  // pin forces low
  // Gate on the raw pin so the shutdown needs no clock edge
  assign gate_high = high_q & trip_pin;
  assign gate_low  = low_q & trip_pin;

endmodule

// [tpc_pkg.sv]
// Constants, field layout and carrier types of the three-phase modulator block
package tpc_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [31:0] TPC_ADDR_CONTROL  = 32'hFFFFFC00;
  localparam logic [31:0] TPC_ADDR_STATUS   = 32'hFFFFFC04;
  localparam logic [31:0] TPC_ADDR_CHOPCFG  = 32'hFFFFFC10;
  localparam logic [31:0] TPC_ADDR_PERIOD   = 32'h0FFFFC08;
  localparam logic [31:0] TPC_ADDR_DEADTIME = 32'h0FFFFC0C;
  localparam logic [31:0] TPC_ADDR_DUTY0    = 32'h0FFFFC14;
  localparam logic [31:0] TPC_ADDR_DUTY1    = 32'h0FFFFC18;
  localparam logic [31:0] TPC_ADDR_DUTY2    = 32'h0FFFFC1C;
  localparam logic [31:0] TPC_ADDR_OUTEN    = 32'h0FFFFC20;
  localparam logic [31:0] TPC_ADDR_SYNCW    = 32'h0FFFFC24;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int TPC_CTL_SYNCSRC  = 4;
  localparam int TPC_CTL_SYNCTYPE = 3;
  localparam int TPC_CTL_DOUBLE   = 2;
  localparam int TPC_CTL_SYNCEN   = 1;
  localparam int TPC_CTL_ENABLE   = 0;
  localparam int TPC_STA_SYNCINT  = 9;
  localparam int TPC_STA_TRIPINT  = 8;
  localparam int TPC_STA_TRIPPIN  = 3;
  localparam int TPC_STA_PHASE    = 0;
  localparam int TPC_CFG_LOW_SIDE_CHOP_ENABLE   = 9;
  localparam int TPC_CFG_HIGH_SIDE_CHOP_ENABLE   = 8;
  localparam int TPC_OEN_XOVR0    = 8;
  localparam int TPC_OEN_DIS_TOP  = 5;

  // ************************************************************
  // Field widths and reset values
  // ************************************************************
  localparam int TPC_CTL_W   = 5;
  localparam int TPC_CFG_W   = 10;
  localparam int TPC_OEN_W   = 9;
  localparam int TPC_DEAD_W  = 10;
  localparam int TPC_SYNCW_W = 10;
  localparam int TPC_CNT_W   = 16;
  localparam int TPC_CHOP_W  = 8;
  localparam int TPC_NCHAN   = 3;

  localparam logic [TPC_CTL_W-1:0]   TPC_RST_CONTROL = 5'h00;
  localparam logic [TPC_CFG_W-1:0]   TPC_RST_CHOPCFG = 10'h000;
  localparam logic [TPC_OEN_W-1:0]   TPC_RST_OUTEN   = 9'h000;
  localparam logic [TPC_CNT_W-1:0]   TPC_RST_WORD    = 16'h0000;
  localparam logic [TPC_DEAD_W-1:0]  TPC_RST_DEAD    = 10'h000;
  localparam logic [TPC_SYNCW_W-1:0] TPC_RST_SYNCW   = 10'h000;
  localparam logic [TPC_SYNCW_W-1:0] TPC_SYNCW_MIN   = 10'h001;
  localparam logic [3:0]             TPC_REWRITE_ALL = 4'hF;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    TPC_ST_IDLE,
    TPC_ST_DOWN,
    TPC_ST_UP
  } tpc_count_e;

  typedef struct packed {
    logic crossover;
    logic dis_high;
    logic dis_low;
    logic chop_high;
    logic chop_low;
  } tpc_chan_ctrl_s;

endpackage

// [tpc_pwm_monitor.sv]
// Port-level assertions for the three-phase modulator, bound to its top
`timescale 1ns/1ps
module tpc_pwm_monitor
  import tpc_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  input wire logic                 fault_trip_pin,
  input wire logic                 ext_sync_in,
  input wire logic [TPC_NCHAN-1:0] gate_high,
  input wire logic [TPC_NCHAN-1:0] gate_low,
  input wire logic                 sync_output_pulse
);
  // *****
  // Checks
  // *****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_sta = psel && penable && !pwrite && paddr == TPC_ADDR_STATUS;
  wire rd_ctl = psel && penable && !pwrite && paddr == TPC_ADDR_CONTROL;
  wire mapped = paddr inside {TPC_ADDR_CONTROL, TPC_ADDR_STATUS, TPC_ADDR_CHOPCFG,
    TPC_ADDR_PERIOD, TPC_ADDR_DEADTIME, TPC_ADDR_DUTY0, TPC_ADDR_DUTY1,
    TPC_ADDR_DUTY2, TPC_ADDR_OUTEN, TPC_ADDR_SYNCW};
  // Pin level needs the synchroniser depth before status may show it
  sequence pin_high3; fault_trip_pin [*3]; endsequence
  sequence pin_low3; !fault_trip_pin [*3]; endsequence
  sequence pin_low6; !fault_trip_pin [*6]; endsequence
  trip_gates_a: assert property (!fault_trip_pin |-> !(|{gate_high, gate_low}))
    else $error("gate driven during trip");
  trip_sync_a: assert property (!fault_trip_pin |-> !sync_output_pulse)
    else $error("sync pulse during trip");
  gate_overlap_a: assert property (!(|(gate_high & gate_low)))
    else $error("both gates of a channel on");
  pin_high_a: assert property (pin_high3 ##0 rd_sta |-> prdata[TPC_STA_TRIPPIN])
    else $error("status misses high trip pin");
  pin_low_a: assert property (pin_low3 ##0 rd_sta |-> !prdata[TPC_STA_TRIPPIN])
    else $error("status misses low trip pin");
  trip_enable_a: assert property (pin_low6 ##0 rd_ctl |-> !prdata[TPC_CTL_ENABLE])
    else $error("enable still set after trip");
  status_rsvd_a: assert property (rd_sta |-> (prdata & ~32'h00000309) == 32'h0)
    else $error("reserved status bit set");
  unmapped_a: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule
bind tpc_pwm_top tpc_pwm_monitor u_tpc_pwm_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .fault_trip_pin(fault_trip_pin),
  .ext_sync_in(ext_sync_in), .gate_high(gate_high), .gate_low(gate_low),
  .sync_output_pulse(sync_output_pulse));

// [tpc_pwm_top.sv]
// Three-phase center-aligned modulator with APB register file
`timescale 1ns/1ps
module tpc_pwm_top
  import tpc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output wire logic                  pready,
  output wire logic [31:0]           prdata,
  output wire logic                  pslverr,
  input  wire logic                  fault_trip_pin,
  input  wire logic                  ext_sync_in,
  output wire logic [TPC_NCHAN-1:0]  gate_high,
  output wire logic [TPC_NCHAN-1:0]  gate_low,
  output wire logic                  sync_output_pulse
);

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [TPC_CTL_W-1:0]   modulator_control;
  logic [TPC_CFG_W-1:0]   gate_chopping_config;
  logic [TPC_OEN_W-1:0]   output_enable_crossover;
  logic [TPC_CNT_W-1:0]   switching_period;
  logic [TPC_DEAD_W-1:0]  dead_time;
  logic [TPC_CNT_W-1:0]   duty_reg [TPC_NCHAN];
  logic [TPC_SYNCW_W-1:0] sync_pulse_width;
  logic                   sync_interrupt_flag;
  logic                   trip_interrupt_flag;
  logic                   tripped;
  logic [3:0]             rewrite_mask;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire logic access   = psel & penable;
  wire logic wr       = access & pwrite;
  wire logic hit_ctl  = paddr == TPC_ADDR_CONTROL;
  wire logic hit_sta  = paddr == TPC_ADDR_STATUS;
  wire logic hit_cfg  = paddr == TPC_ADDR_CHOPCFG;
  wire logic hit_per  = paddr == TPC_ADDR_PERIOD;
  wire logic hit_dead = paddr == TPC_ADDR_DEADTIME;
  wire logic hit_d0   = paddr == TPC_ADDR_DUTY0;
  wire logic hit_d1   = paddr == TPC_ADDR_DUTY1;
  wire logic hit_d2   = paddr == TPC_ADDR_DUTY2;
  wire logic hit_oen  = paddr == TPC_ADDR_OUTEN;
  wire logic hit_syw  = paddr == TPC_ADDR_SYNCW;
  wire logic hit_any  = hit_ctl | hit_sta | hit_cfg | hit_per | hit_dead |
                        hit_d0 | hit_d1 | hit_d2 | hit_oen | hit_syw;
  wire logic [TPC_NCHAN-1:0] hit_duty = {hit_d2, hit_d1, hit_d0};

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  // ************************************************************
  // Control fields
  // ************************************************************
  wire logic sync_source_select = modulator_control[TPC_CTL_SYNCSRC];
  wire logic external_sync_type = modulator_control[TPC_CTL_SYNCTYPE];
  wire logic double_update_mode = modulator_control[TPC_CTL_DOUBLE];
  wire logic sync_enable        = modulator_control[TPC_CTL_SYNCEN];
  wire logic master_enable      = modulator_control[TPC_CTL_ENABLE];
  wire logic low_side_chop_enable  = gate_chopping_config[TPC_CFG_LOW_SIDE_CHOP_ENABLE];
  wire logic high_side_chop_enable = gate_chopping_config[TPC_CFG_HIGH_SIDE_CHOP_ENABLE];
  wire logic [TPC_CHOP_W-1:0] chopping_period = gate_chopping_config[TPC_CHOP_W-1:0];

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] trip_sync;
  logic [2:0] ext_sync;
  logic       trip_level;
  logic       ext_level_q;
  logic       ext_prev;

  // sync type select
  // A synchronous source skips the resynchroniser and saves its latency
  wire logic ext_level = external_sync_type ? ext_sync_in : ext_level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_sync   <= 3'h0;
      ext_sync    <= 3'h0;
      trip_level  <= 1'b0;
      ext_level_q <= 1'b0;
      ext_prev    <= 1'b0;
    end else begin
      trip_sync <= {trip_sync[1:0], fault_trip_pin};
      ext_sync  <= {ext_sync[1:0], ext_sync_in};
      if (trip_sync[1] == trip_sync[2]) begin
        trip_level <= trip_sync[2];
      end
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level_q <= ext_sync[2];
      end
      ext_prev <= ext_level;
    end
  end

  wire logic ext_edge  = ext_level & ~ext_prev;
  wire logic use_ext   = sync_source_select & sync_enable;
  // Trip counts once the filtered level falls
  wire logic trip_event = (trip_sync[1] == trip_sync[2]) & ~trip_sync[2] & trip_level;

  // ************************************************************
  // Period counter
  // ************************************************************
  tpc_count_e             state;
  tpc_count_e             next_state;
  logic [TPC_CNT_W-1:0]   count;
  logic [TPC_CNT_W-1:0]   next_count;
  logic [TPC_CNT_W-1:0]   period_l;
  logic                   period_start;
  logic                   midpoint;

  wire logic run_ok = master_enable & ~tripped & trip_level;

  always_comb begin
    next_state   = state;
    next_count   = count;
    period_start = 1'b0;
    midpoint     = 1'b0;
    case (state)
      TPC_ST_IDLE: begin
        period_start = run_ok & (~use_ext | ext_edge);
      end
      TPC_ST_DOWN: begin
        if (count == TPC_RST_WORD) begin
          midpoint   = 1'b1;
          next_state = TPC_ST_UP;
        end else begin
          next_count = count - 16'h0001;
        end
      end
      TPC_ST_UP: begin
        if (count >= period_l) begin
          period_start = ~use_ext;
        end else begin
          next_count = count + 16'h0001;
        end
      end
      default: begin
        next_state = TPC_ST_IDLE;
      end
    endcase
    if (state != TPC_ST_IDLE && use_ext && ext_edge) begin
      period_start = 1'b1;
    end
    if (period_start) begin
      next_state = TPC_ST_DOWN;
      next_count = switching_period;
    end
    if (!run_ok) begin
      next_state   = TPC_ST_IDLE;
      next_count   = TPC_RST_WORD;
      period_start = 1'b0;
      midpoint     = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= TPC_ST_IDLE;
      count    <= TPC_RST_WORD;
      period_l <= TPC_RST_WORD;
    end else begin
      state <= next_state;
      count <= next_count;
      if (period_start) begin
        period_l <= switching_period;
      end
    end
  end

  // ************************************************************
  // Duty latches and output stages
  // ************************************************************
  // update rate select
  wire logic duty_update = period_start | (double_update_mode & midpoint);
  wire logic run_q       = state != TPC_ST_IDLE;

  logic [TPC_CHOP_W-1:0] chop_cnt;
  logic                  chop_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_cnt <= 8'h00;
      chop_clk <= 1'b0;
    end else if (chop_cnt == chopping_period) begin
      chop_cnt <= 8'h00;
      chop_clk <= ~chop_clk;
    end else begin
      chop_cnt <= chop_cnt + 8'h01;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < TPC_NCHAN; ch++) begin : g_chan
      logic [TPC_CNT_W-1:0] duty_l;
      tpc_chan_ctrl_s       cfg;

      assign cfg.crossover = output_enable_crossover[TPC_OEN_XOVR0-ch];
      assign cfg.dis_low   = output_enable_crossover[TPC_OEN_DIS_TOP-2*ch];
      assign cfg.dis_high  = output_enable_crossover[TPC_OEN_DIS_TOP-1-2*ch];
      assign cfg.chop_high = high_side_chop_enable;
      assign cfg.chop_low  = low_side_chop_enable;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          duty_l <= TPC_RST_WORD;
        end else if (duty_update) begin
          duty_l <= duty_reg[ch];
        end
      end

      tpc_phase_out u_out (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (run_q),
        .count     (count),
        .duty      (duty_l),
        .dead      (dead_time),
        .ctrl      (cfg),
        .chop_clk  (chop_clk),
        .trip_pin  (fault_trip_pin),
        .gate_high (gate_high[ch]),
        .gate_low  (gate_low[ch])
      );
    end
  endgenerate

  // ************************************************************
  // Sync output pulse
  // ************************************************************
  logic [TPC_SYNCW_W-1:0] sync_cnt;
  wire logic              sync_fire = period_start & sync_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt <= TPC_RST_SYNCW;
    end else if (sync_fire) begin
      sync_cnt <= (sync_pulse_width == TPC_RST_SYNCW) ? TPC_SYNCW_MIN : sync_pulse_width;
    end else if (sync_cnt != TPC_RST_SYNCW) begin
      sync_cnt <= sync_cnt - 10'h001;
    end
  end

  assign sync_output_pulse = (sync_cnt != TPC_RST_SYNCW) & fault_trip_pin;

  // ************************************************************
  // Register writes
  // ************************************************************
  wire logic [TPC_CTL_W-1:0] ctl_wdata = pwdata[TPC_CTL_W-1:0];
  wire logic                 rearm     = tripped & (rewrite_mask == TPC_REWRITE_ALL) & trip_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulator_control <= TPC_RST_CONTROL;
      tripped           <= 1'b0;
      rewrite_mask      <= 4'h0;
    end else begin
      if (wr && hit_ctl) begin
        modulator_control <= tripped ? {ctl_wdata[TPC_CTL_W-1:1], 1'b0} : ctl_wdata;
      end
      if (tripped && wr) begin
        rewrite_mask <= rewrite_mask | {hit_d2, hit_d1, hit_d0, hit_per};
      end
      if (rearm) begin
        modulator_control[TPC_CTL_ENABLE] <= 1'b1;
        tripped      <= 1'b0;
        rewrite_mask <= 4'h0;
      end
      // trip clears enable
      // Trip is last so it beats any software write in the same cycle
      if (trip_event) begin
        modulator_control[TPC_CTL_ENABLE] <= 1'b0;
        tripped      <= 1'b1;
        rewrite_mask <= 4'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_chopping_config    <= TPC_RST_CHOPCFG;
      output_enable_crossover <= TPC_RST_OUTEN;
      switching_period        <= TPC_RST_WORD;
      dead_time               <= TPC_RST_DEAD;
      sync_pulse_width        <= TPC_RST_SYNCW;
    end else if (wr) begin
      if (hit_cfg) begin
        gate_chopping_config <= pwdata[TPC_CFG_W-1:0];
      end
      if (hit_oen) begin
        output_enable_crossover <= pwdata[TPC_OEN_W-1:0];
      end
      if (hit_per) begin
        switching_period <= pwdata[TPC_CNT_W-1:0];
      end
      if (hit_dead) begin
        dead_time <= pwdata[TPC_DEAD_W-1:0];
      end
      if (hit_syw) begin
        sync_pulse_width <= pwdata[TPC_SYNCW_W-1:0];
      end
    end
  end

  generate
    for (ch = 0; ch < TPC_NCHAN; ch++) begin : g_duty_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          duty_reg[ch] <= TPC_RST_WORD;
        end else if (wr && hit_duty[ch]) begin
          duty_reg[ch] <= pwdata[TPC_CNT_W-1:0];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Interrupt flags
  // ************************************************************
  wire logic clr_sync = wr & hit_sta & pwdata[TPC_STA_SYNCINT];
  wire logic clr_trip = wr & hit_sta & pwdata[TPC_STA_TRIPINT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_interrupt_flag <= 1'b0;
      trip_interrupt_flag <= 1'b0;
    end else begin
      sync_interrupt_flag <= sync_fire | (sync_interrupt_flag & ~clr_sync);
      trip_interrupt_flag <= trip_event | (trip_interrupt_flag & ~clr_trip);
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  // pin level in status
  // count direction in status
  // Pin level is taken after two stages to stay clear of metastability
  wire logic [15:0] status_word = {6'h00, sync_interrupt_flag, trip_interrupt_flag,
                                   4'h0, trip_sync[1], 2'h0, state == TPC_ST_DOWN};
  wire logic [31:0] rd_word =
      hit_ctl  ? {27'h0, modulator_control} :
      hit_sta  ? {16'h0, status_word} :
      hit_cfg  ? {22'h0, gate_chopping_config} :
      hit_per  ? {16'h0, switching_period} :
      hit_dead ? {22'h0, dead_time} :
      hit_d0   ? {16'h0, duty_reg[0]} :
      hit_d1   ? {16'h0, duty_reg[1]} :
      hit_d2   ? {16'h0, duty_reg[2]} :
      hit_oen  ? {23'h0, output_enable_crossover} :
      hit_syw  ? {22'h0, sync_pulse_width} :
      32'h00000000;

  assign prdata = (access && !pwrite) ? rd_word : 32'h00000000;

endmodule

// [tpc_pwm_top_tb.sv]
// Self-checking register-level testbench for the three-phase modulator
`timescale 1ns/1ps
module tpc_pwm_top_tb
  import tpc_pkg::*;
;
  localparam logic [31:0] ADR [9] = '{TPC_ADDR_CONTROL, TPC_ADDR_CHOPCFG, TPC_ADDR_PERIOD,
    TPC_ADDR_DEADTIME, TPC_ADDR_DUTY0, TPC_ADDR_DUTY1, TPC_ADDR_DUTY2, TPC_ADDR_OUTEN,
    TPC_ADDR_SYNCW};
  localparam logic [31:0] MSK [9] = '{32'h1F, 32'h3FF, 32'hFFFF, 32'h3FF, 32'hFFFF,
    32'hFFFF, 32'hFFFF, 32'h1FF, 32'h3FF};
  localparam logic [31:0] OEN [4] = '{32'h3F, 32'h10, 32'h1, 32'h20};
  localparam logic [6:0]  GSN [4] = '{7'h40, 7'h77, 7'h5F, 7'h7E};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        trip_cmd = 1'b0;
  logic        sync_cmd = 1'b0;
  logic [31:0] rdata;
  logic [6:0]  seen;
  logic [1:0]  ph;
  int          failures = 0;
  int          checks = 0;
  wire         pready, pslverr, fault_trip_pin, ext_sync_in, sync_output_pulse;
  wire [31:0]  prdata;
  wire [2:0]   gate_high, gate_low;
  tpc_pwm_top u_tpc_pwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fault_trip_pin(fault_trip_pin), .ext_sync_in(ext_sync_in),
    .gate_high(gate_high), .gate_low(gate_low), .sync_output_pulse(sync_output_pulse));
  tpc_drive_model u_tpc_drive_model (.pclk(pclk), .trip_cmd(trip_cmd), .sync_cmd(sync_cmd),
    .fault_trip_pin(fault_trip_pin), .ext_sync_in(ext_sync_in));
  initial forever #20 pclk = ~pclk;
  // *****
  // Bus tasks
  // *****
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until pready is sampled high, then released at that edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata & m);
  endtask
  task automatic duties();
    for (int i = 4; i < 7; i++) begin
      apb(1'b1, ADR[i], 32'hA);
    end
  endtask
  task automatic watch(input int n);
    seen = 7'h00;
    repeat (n) begin
      @(posedge pclk);
      seen = seen | {sync_output_pulse, gate_high, gate_low};
    end
  endtask
  // *****
  // Main sequence
  // *****
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdchk("reset value", ADR[i], 32'hFFFFFFFF, 32'h0);
    end
    rdchk("status reset", TPC_ADDR_STATUS, 32'hFFFFFFFE, 32'h8);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, ADR[i], 32'hFFFFFFFF);
      rdchk("readback", ADR[i], 32'hFFFFFFFF, MSK[i]);
    end
    apb(1'b0, 32'h0FFFFC10, 32'h0);
    chk("unmapped", 32'h0, rdata);
    apb(1'b1, TPC_ADDR_CONTROL, 32'h0);
    apb(1'b1, TPC_ADDR_CHOPCFG, 32'h0);
    apb(1'b1, TPC_ADDR_PERIOD, 32'h14);
    apb(1'b1, TPC_ADDR_DEADTIME, 32'h2);
    apb(1'b1, TPC_ADDR_SYNCW, 32'h1);
    duties();
    apb(1'b1, TPC_ADDR_CONTROL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, TPC_ADDR_OUTEN, OEN[i]);
      watch(100);
      chk("gates seen", {25'h0, GSN[i]}, {25'h0, seen});
    end
    ph = 2'b00;
    repeat (30) begin
      apb(1'b0, TPC_ADDR_STATUS, 32'h0);
      ph = ph | (rdata[TPC_STA_PHASE] ? 2'b10 : 2'b01);
    end
    chk("phase both", 32'h3, {30'h0, ph});
    apb(1'b1, TPC_ADDR_CONTROL, 32'h2);
    apb(1'b1, TPC_ADDR_STATUS, 32'h0);
    rdchk("sync flag held", TPC_ADDR_STATUS, 32'h200, 32'h200);
    apb(1'b1, TPC_ADDR_STATUS, 32'h200);
    rdchk("sync flag clear", TPC_ADDR_STATUS, 32'h200, 32'h0);
    apb(1'b1, TPC_ADDR_PERIOD, 32'hFFF);
    apb(1'b1, TPC_ADDR_CONTROL, 32'h1B);
    watch(20);
    chk("no internal sync", 32'h0, {31'h0, seen[6]});
    sync_cmd <= 1'b1;
    @(posedge pclk);
    sync_cmd <= 1'b0;
    watch(12);
    chk("external sync", 32'h1, {31'h0, seen[6]});
    trip_cmd <= 1'b1;
    repeat (2) @(posedge pclk);
    watch(10);
    chk("trip gates", 32'h0, {25'h0, seen});
    rdchk("trip status", TPC_ADDR_STATUS, 32'h108, 32'h100);
    rdchk("trip enable", TPC_ADDR_CONTROL, 32'h1, 32'h0);
    trip_cmd <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, TPC_ADDR_CONTROL, 32'h1B);
    rdchk("no restart", TPC_ADDR_CONTROL, 32'h1, 32'h0);
    apb(1'b1, TPC_ADDR_PERIOD, 32'h14);
    duties();
    rdchk("restart", TPC_ADDR_CONTROL, 32'h1, 32'h1);
    apb(1'b1, TPC_ADDR_STATUS, 32'h100);
    rdchk("trip clear", TPC_ADDR_STATUS, 32'h100, 32'h0);
    apb(1'b1, TPC_ADDR_DUTY0, 32'h0);
    apb(1'b1, TPC_ADDR_OUTEN, 32'h100);
    apb(1'b1, TPC_ADDR_CONTROL, 32'h3);
    watch(100);
    chk("crossover", 32'h7E, {25'h0, seen});
    complete_run();
  end
endmodule
